// File: shared/sms_defines.vh
// Shared constants for the safety module state supervisor.
// Assumes a 40 MHz device clock; included by bare name.
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH
`define SMS_CLK_HZ 40000000
`define SMS_POWERON_MS 1000
`define SMS_POWERON_CYC ((`SMS_CLK_HZ / 1000) * `SMS_POWERON_MS)
`define SMS_FLASH_ON_MS 250
`define SMS_FLASH_ON_CYC ((`SMS_CLK_HZ / 1000) * `SMS_FLASH_ON_MS)
`define SMS_FLASH_GAP_MS 250
`define SMS_FLASH_GAP_CYC ((`SMS_CLK_HZ / 1000) * `SMS_FLASH_GAP_MS)
`define SMS_REPEAT_GAP_MS 1500
`define SMS_REPEAT_GAP_CYC ((`SMS_CLK_HZ / 1000) * `SMS_REPEAT_GAP_MS)
`define SMS_CLS_NONE 3'h0
`define SMS_CLS_FATAL 3'h1
`define SMS_CLS_OVERCUR 3'h2
`define SMS_CLS_SHORT 3'h3
`define SMS_CLS_TEMP 3'h4
`define SMS_CLS_APP 3'h5
`define SMS_LED_OFF 2'h0
`define SMS_LED_RED 2'h1
`define SMS_LED_BLUE 2'h2
`endif

// File: hdl/sms_sync2.v
// Two-flop synchroniser bank for inputs from outside the clock domain.
// Assumes inputs are asynchronous levels; first stage feeds only the second.
`timescale 1ns/1ps
module sms_sync2 #(
  parameter WIDTH = 1
) (
  input wire i_mclk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_reg; // First stage, read only by o_sync

  // Two stages, cleared on reset
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // sms_sync2

// File: hdl/sms_supervisor.v
// Safety module state supervisor: power-on, run and latched error states,
// safety output forcing, signalling output freeze and processor flash codes.
// Assumes i_rst is asserted by power-on only; fault inputs are pins.
// Safety output bit high means closed; low is the open, safe condition.
// Indicator codes: 0 dark, 1 red, 2 blue; both indicators always match.
`timescale 1ns/1ps
`include "sms_defines.vh"
module sms_supervisor #(
  parameter N_SAFE = 4,
  parameter N_SIG = 4,
  parameter N_IN = 8,
  parameter CODE_W = 4,
  // Timing counts in device clock cycles
  parameter [31:0] POWERON_CYC = `SMS_POWERON_CYC,
  parameter [31:0] FLASH_ON_CYC = `SMS_FLASH_ON_CYC,
  parameter [31:0] FLASH_GAP_CYC = `SMS_FLASH_GAP_CYC,
  parameter [31:0] REPEAT_GAP_CYC = `SMS_REPEAT_GAP_CYC
) (
  input wire i_mclk,
  input wire i_rst,
  // Pin-level inputs; each passes the synchroniser
  input wire i_diag_done,
  input wire i_diag_fail,
  input wire i_hw_fault,
  input wire i_overcurrent,
  input wire i_safe_short,
  input wire i_temp_fault,
  input wire i_app_error,
  input wire [CODE_W-1:0] i_app_error_code,
  input wire [N_SAFE-1:0] i_app_safety_out,
  input wire [N_SIG-1:0] i_app_signal_out,
  input wire [N_IN-1:0] i_system_in,
  input wire i_supply_ok,
  // Outputs, every one a flip-flop
  output reg o_program_run,
  output reg [N_IN-1:0] o_program_in,
  output reg [N_SAFE-1:0] o_safety_output_n,
  output reg [N_SIG-1:0] o_signalling_output_n,
  output reg [1:0] o_processor_indicator_a,
  output reg [1:0] o_processor_indicator_b,
  output reg o_supply_indicator,
  output reg [N_IN-1:0] o_input_indicator,
  output reg [N_SIG-1:0] o_output_indicator,
  output reg o_in_error
);
  // Supervisor states
  localparam [1:0] ST_POWERON = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_ERROR = 2'h2;
  // Fourth code is unused and falls into a fatal error
  // Flash sequencer phases
  localparam [1:0] FL_RED = 2'h0;
  localparam [1:0] FL_BLUE = 2'h1;
  localparam [1:0] FL_GAP = 2'h2;
  localparam [1:0] FL_PAUSE = 2'h3;
  // Synchroniser width: seven single-bit pins plus the words and supply
  localparam SYN_W = 7 + CODE_W + N_SAFE + N_SIG + N_IN + 1;

  // Synchronised copies of each pin
  wire [SYN_W-1:0] syn_bus; // All pins after two flops
  wire s_done, s_fail, s_hw, s_oc, s_short, s_temp, s_app, s_supply;
  wire [CODE_W-1:0] s_code;
  wire [N_SAFE-1:0] s_safe;
  wire [N_SIG-1:0] s_sig;
  wire [N_IN-1:0] s_in;

  // Registered state and its next value
  reg [1:0] state_reg; // Supervisor state
  reg [1:0] state_next;
  // One timer serves both the lead-in and each flash phase
  reg [31:0] timer_reg; // Power-on and flash phase timer
  reg [31:0] timer_next;
  // Class and code are captured once, on error entry
  reg [2:0] cls_reg; // Latched fault class
  reg [2:0] cls_next;
  reg [CODE_W-1:0] code_reg; // Latched application code
  reg [CODE_W-1:0] code_next;
  reg [1:0] fl_reg; // Flash phase
  reg [1:0] fl_next;
  reg [CODE_W-1:0] cnt_reg; // Blue flashes shown so far
  reg [CODE_W-1:0] cnt_next;
  // Indicator colour and the class decoded this cycle
  reg [1:0] led_next; // Shared colour for both indicators
  reg [2:0] fault_cls; // Class of the fault seen this cycle

  // Single synchroniser for every pin-level input
  // One wide bank keeps every pin at the same two-cycle latency,
  // so a fault and its code arrive together
  sms_sync2 #(
    .WIDTH(SYN_W)
  ) i_sms_sync2 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_diag_done, i_diag_fail, i_hw_fault, i_overcurrent, i_safe_short, i_temp_fault,
      i_app_error, i_app_error_code, i_app_safety_out, i_app_signal_out, i_system_in, i_supply_ok}),
    .o_sync(syn_bus)
  );
  // Split the bank back into named signals, in the same order
  assign {s_done, s_fail, s_hw, s_oc, s_short, s_temp, s_app, s_code, s_safe, s_sig, s_in, s_supply} = syn_bus;

  // Blue count for a class; restorable classes start with one red flash
  function [CODE_W-1:0] blue_count;
    input [2:0] cls;
    input [CODE_W-1:0] code;
    begin
      // Fatal and none classes carry no blue flashes
      case (cls)
        `SMS_CLS_OVERCUR: blue_count = {{(CODE_W-1){1'b0}}, 1'b1};
        `SMS_CLS_SHORT: blue_count = {{(CODE_W-2){1'b0}}, 2'b10};
        `SMS_CLS_TEMP: blue_count = {{(CODE_W-2){1'b0}}, 2'b11};
        `SMS_CLS_APP: blue_count = code;
        default: blue_count = {CODE_W{1'b0}};
      endcase
    end
  endfunction

  // Opening phase of a sequence; application code zero stays dark
  function [1:0] first_phase;
    input [2:0] cls;
    input [CODE_W-1:0] code;
    begin
      if (cls != `SMS_CLS_APP)
        first_phase = FL_RED;
      else if (code == {CODE_W{1'b0}})
        first_phase = FL_PAUSE;
      else
        first_phase = FL_BLUE;
    end
  endfunction

  // Fault priority: internal hardware beats restorable, application last
  // Only one class latches; a lower fault seen at once is not shown
  always @*
  begin
    if (s_hw)
      fault_cls = `SMS_CLS_FATAL;
    else if (s_oc)
      fault_cls = `SMS_CLS_OVERCUR;
    else if (s_short)
      fault_cls = `SMS_CLS_SHORT;
    else if (s_temp)
      fault_cls = `SMS_CLS_TEMP;
    // Application request only when no internal detector fired
    else if (s_app)
      fault_cls = `SMS_CLS_APP;
    else
      fault_cls = `SMS_CLS_NONE;
  end

  // Next-state and indicator sequencing
  always @*
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    cls_next = cls_reg;
    code_next = code_reg;
    fl_next = fl_reg;
    cnt_next = cnt_reg;
    led_next = `SMS_LED_OFF;
    // Defaults hold every register; indicators dark unless a branch lights them
    case (state_reg)
      // Power-on: red lead-in while self-diagnosis runs
      ST_POWERON:
      begin
        led_next = `SMS_LED_RED;
        // Timer saturates so a slow diagnosis cannot wrap it
        if (timer_reg < POWERON_CYC - 32'h0000_0001)
          timer_next = timer_reg + 32'h0000_0001;
        // Hold red for the full second even if diagnosis ends early
        if (s_done && timer_reg >= POWERON_CYC - 32'h0000_0001)
        begin
          timer_next = 32'h0000_0000;
          if (s_fail)
          begin
            state_next = ST_ERROR;
            cls_next = `SMS_CLS_FATAL;
          end
          else
          begin
            // Dark from the very edge the program starts
            state_next = ST_RUN;
            led_next = `SMS_LED_OFF;
          end
        end
      end
      // Run: program executes; any fault class enters error
      ST_RUN:
      begin
        led_next = `SMS_LED_OFF;
        if (fault_cls != `SMS_CLS_NONE)
        begin
          state_next = ST_ERROR;
          cls_next = fault_cls;
          // Code latched with the class so later pin changes cannot alter it
          code_next = s_code;
          timer_next = 32'h0000_0000;
          cnt_next = {CODE_W{1'b0}};
          // Application codes have no red lead-in; code zero only pauses
          fl_next = first_phase(fault_cls, s_code);
        end
      end
      // Error: flash sequencer or steady red, never left
      ST_ERROR:
      begin
        // No exit branch: only reset from a power cycle leaves here
        state_next = ST_ERROR;
        // Fatal classes never flash, so the timer stays idle
        if (cls_reg == `SMS_CLS_FATAL)
          led_next = `SMS_LED_RED;
        else
        begin
          timer_next = timer_reg + 32'h0000_0001;
          case (fl_reg)
            // Red lead-in flash of a restorable code
            FL_RED:
            begin
              led_next = `SMS_LED_RED;
              if (timer_reg >= FLASH_ON_CYC - 32'h0000_0001)
              begin
                timer_next = 32'h0000_0000;
                fl_next = FL_GAP;
              end
            end
            // One blue flash; the count decides gap or pause
            FL_BLUE:
            begin
              led_next = `SMS_LED_BLUE;
              if (timer_reg >= FLASH_ON_CYC - 32'h0000_0001)
              begin
                timer_next = 32'h0000_0000;
                cnt_next = cnt_reg + {{(CODE_W-1){1'b0}}, 1'b1};
                fl_next = (cnt_reg + {{(CODE_W-1){1'b0}}, 1'b1} >= blue_count(cls_reg, code_reg))
                  ? FL_PAUSE : FL_GAP;
              end
            end
            // Short dark gap between flashes
            FL_GAP:
            begin
              if (timer_reg >= FLASH_GAP_CYC - 32'h0000_0001)
              begin
                timer_next = 32'h0000_0000;
                fl_next = (blue_count(cls_reg, code_reg) == {CODE_W{1'b0}}) ? FL_PAUSE : FL_BLUE;
              end
            end
            FL_PAUSE:
            begin
              // Longer dark gap marks the start of the next repetition
              if (timer_reg >= REPEAT_GAP_CYC - 32'h0000_0001)
              begin
                timer_next = 32'h0000_0000;
                cnt_next = {CODE_W{1'b0}};
                fl_next = first_phase(cls_reg, code_reg);
              end
            end
            // Unused phase code recovers through the pause
            default:
              fl_next = FL_PAUSE;
          endcase
        end
      end
      // Illegal state code treated as a fatal fault
      default:
      begin
        state_next = ST_ERROR;
        cls_next = `SMS_CLS_FATAL;
      end
    endcase
  end

  // State registers and outputs
  // Indicators follow the phase one edge later; run, error and safety outputs use the next state
  always @(posedge i_mclk)
  begin
    // Power-on reset: indicators red, every other output low
    if (i_rst)
    begin
      state_reg <= ST_POWERON;
      timer_reg <= 32'h0000_0000;
      cls_reg <= `SMS_CLS_NONE;
      code_reg <= {CODE_W{1'b0}};
      fl_reg <= FL_RED;
      cnt_reg <= {CODE_W{1'b0}};
      o_program_run <= 1'b0;
      o_program_in <= {N_IN{1'b0}};
      o_safety_output_n <= {N_SAFE{1'b0}};
      o_signalling_output_n <= {N_SIG{1'b0}};
      o_processor_indicator_a <= `SMS_LED_RED;
      o_processor_indicator_b <= `SMS_LED_RED;
      o_supply_indicator <= 1'b0;
      o_input_indicator <= {N_IN{1'b0}};
      o_output_indicator <= {N_SIG{1'b0}};
      o_in_error <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      cls_reg <= cls_next;
      code_reg <= code_next;
      fl_reg <= fl_next;
      cnt_reg <= cnt_next;
      o_processor_indicator_a <= led_next;
      o_processor_indicator_b <= led_next;
      // From next state, so the flag rises with the safety outputs opening
      o_in_error <= (state_next == ST_ERROR);
      // Green indicators track their signals in every state
      o_supply_indicator <= s_supply;
      o_input_indicator <= s_in;
      o_output_indicator <= o_signalling_output_n;
      // Run: outputs follow the program each cycle
      if (state_next == ST_RUN)
      begin
        o_program_run <= 1'b1;
        o_program_in <= s_in;
        o_safety_output_n <= s_safe;
        o_signalling_output_n <= s_sig;
      end
      else
      begin
        // Power-on and error alike keep the safety outputs open
        o_program_run <= 1'b0;
        o_safety_output_n <= {N_SAFE{1'b0}};
        // Program inputs and signalling outputs keep their last values
        o_program_in <= o_program_in;
        o_signalling_output_n <= o_signalling_output_n;
      end
    end
  end
endmodule // sms_supervisor

// File: dv/sms_sup_asserts.sv
// Port checker for the state supervisor.
// Assumes the bind hands on the short power-on count.
`timescale 1ns/1ps
module sms_sup_asserts #(
  parameter N_SAFE = 4,
  parameter N_SIG = 4,
  parameter N_IN = 8,
  parameter [31:0] POWERON_CYC = 32'h0000_0014
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_supply_ok,
  input wire o_program_run,
  input wire [N_IN-1:0] o_program_in,
  input wire [N_SAFE-1:0] o_safety_output_n,
  input wire [N_SIG-1:0] o_signalling_output_n,
  input wire [1:0] o_processor_indicator_a,
  input wire [1:0] o_processor_indicator_b,
  input wire o_supply_indicator,
  input wire o_in_error
);
  reg [2:0] since_rst_reg; // Edges since reset; pins need 3 to show
  reg [31:0] pon_cnt_reg; // Power-on cycles seen
  // Helper counters, cleared by each power cycle
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      since_rst_reg <= 3'h0;
      pon_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      if (since_rst_reg != 3'h7)
        since_rst_reg <= since_rst_reg + 3'h1;
      if (!o_program_run && !o_in_error)
        pon_cnt_reg <= pon_cnt_reg + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_pon_lead_len: assert property ($rose(o_program_run) |-> pon_cnt_reg >= POWERON_CYC - 1)
    else $error("run entered before red lead-in ended");
  chk_pon_red_show: assert property (!o_program_run && !o_in_error |-> o_processor_indicator_a == 2'h1)
    else $error("power-on indicator not red");
  chk_run_dark: assert property (o_program_run |-> o_processor_indicator_a == 2'h0)
    else $error("indicator lit in run");
  chk_pair_same: assert property (o_processor_indicator_a == o_processor_indicator_b)
    else $error("indicators differ");
  chk_err_open: assert property (o_in_error |-> o_safety_output_n == 0 && !o_program_run)
    else $error("safety output closed in error");
  chk_err_latched: assert property (o_in_error |=> o_in_error)
    else $error("error state left");
  chk_sig_frozen: assert property (o_in_error |=> $stable(o_signalling_output_n))
    else $error("signalling changed in error");
  chk_in_frozen: assert property (o_in_error |=> $stable(o_program_in))
    else $error("program inputs changed in error");
  chk_supply_follow: assert property (since_rst_reg >= 3'h4 |-> o_supply_indicator == $past(i_supply_ok, 3))
    else $error("supply indicator lags");
  cover property ($rose(o_program_run));
  cover property (o_in_error && o_processor_indicator_a == 2'h2);
  cover property ($rose(o_in_error) && o_processor_indicator_a == 2'h1);
endmodule // sms_sup_asserts
bind sms_supervisor sms_sup_asserts #(.N_SAFE(N_SAFE), .N_SIG(N_SIG), .N_IN(N_IN), .POWERON_CYC(POWERON_CYC))
  i_sms_sup_asserts (.i_mclk, .i_rst, .i_supply_ok, .o_program_run, .o_program_in, .o_safety_output_n,
  .o_signalling_output_n, .o_processor_indicator_a, .o_processor_indicator_b, .o_supply_indicator, .o_in_error);

// File: dv/test_sms_supervisor.sv
// Self-checking bench for the state supervisor with short timing.
// Assumes the defines header on the include path; one 40 MHz clock.
`timescale 1ns/1ps
`include "sms_defines.vh"
module test_sms_supervisor;
  localparam PON = 20; // Short power-on count
  reg i_mclk = 1'h0;
  reg i_rst, i_diag_done, i_diag_fail, i_hw_fault, i_overcurrent, i_safe_short, i_temp_fault, i_app_error, i_supply_ok;
  reg [3:0] i_app_error_code, i_app_safety_out, i_app_signal_out;
  reg [7:0] i_system_in;
  wire o_program_run, o_supply_indicator, o_in_error;
  wire [7:0] o_program_in, o_input_indicator;
  wire [3:0] o_safety_output_n, o_signalling_output_n, o_output_indicator;
  wire [1:0] o_processor_indicator_a, o_processor_indicator_b;
  integer bad_count = 0;
  integer tests_run = 0;
  always #12.5 i_mclk = ~i_mclk;
  sms_supervisor #(.POWERON_CYC(PON), .FLASH_ON_CYC(5), .FLASH_GAP_CYC(5), .REPEAT_GAP_CYC(30)) i_sms_supervisor (
    .i_mclk, .i_rst, .i_diag_done, .i_diag_fail, .i_hw_fault, .i_overcurrent, .i_safe_short, .i_temp_fault,
    .i_app_error, .i_app_error_code, .i_app_safety_out, .i_app_signal_out, .i_system_in, .i_supply_ok,
    .o_program_run, .o_program_in, .o_safety_output_n, .o_signalling_output_n, .o_processor_indicator_a,
    .o_processor_indicator_b, .o_supply_indicator, .o_input_indicator, .o_output_indicator, .o_in_error);
  // Compare and count; case equality so unknowns fail
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Drive 2 ns after the edge, away from sampling
  task step(input integer n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask
  // Power cycle: the only way out of error
  task power_cycle;
    {i_diag_done, i_diag_fail, i_hw_fault, i_overcurrent, i_safe_short, i_temp_fault, i_app_error} = 7'h00;
    {i_app_error_code, i_app_safety_out, i_app_signal_out, i_system_in} = 20'h0_0000;
    i_supply_ok = 1'h1;
    i_rst = 1'h1;
    step(8);
    i_rst = 1'h0;
  endtask
  // Pass diagnosis, count red cycles until run
  task reach_run;
    integer n, red;
    power_cycle();
    chk("error after power cycle", o_in_error, 1'h0);
    i_diag_done = 1'h1;
    n = 0;
    red = 0;
    while (o_program_run !== 1'h1 && n < 100)
    begin
      red = red + (o_processor_indicator_a === `SMS_LED_RED);
      n = n + 1;
      step(1);
    end
    chk("red lead cycles", red >= PON - 1, 1'h1);
    chk("dark on run entry", o_processor_indicator_a, `SMS_LED_OFF);
  endtask
  // Bounded wait for the error state
  task wait_err;
    integer n;
    n = 0;
    while (o_in_error !== 1'h1 && n < 100)
    begin
      n = n + 1;
      step(1);
    end
    chk("error entered", o_in_error, 1'h1);
  endtask
  // Count flashes over one period from the first lit cycle
  task flash(input integer r, input integer b, input integer span, input integer gmin, input integer gmax);
    integer n, nr, nb, dk, md;
    reg [1:0] prev;
    n = 0;
    {nr, nb, dk, md} = {4{32'h0000_0000}};
    prev = `SMS_LED_OFF;
    while (o_processor_indicator_a === `SMS_LED_OFF && n < 100)
    begin
      n = n + 1;
      step(1);
    end
    repeat (span)
    begin
      nr = nr + (o_processor_indicator_a !== prev && o_processor_indicator_a === `SMS_LED_RED);
      nb = nb + (o_processor_indicator_a !== prev && o_processor_indicator_a === `SMS_LED_BLUE);
      dk = (o_processor_indicator_a === `SMS_LED_OFF) ? dk + 1 : 0;
      md = (dk > md) ? dk : md;
      prev = o_processor_indicator_a;
      step(1);
    end
    chk("red flashes", nr, r);
    chk("blue flashes", nb, b);
    chk("longest dark", md >= gmin && md <= gmax, 1'h1);
  endtask
  task t_run;
    reach_run();
    i_app_safety_out = 4'hA;
    i_app_signal_out = 4'h6;
    i_system_in = 8'h5C;
    i_supply_ok = 1'h0;
    step(4);
    chk("safety out", o_safety_output_n, 4'hA);
    chk("signal out", o_signalling_output_n, 4'h6);
    chk("program in", o_program_in, 8'h5C);
    chk("supply led", o_supply_indicator, 1'h0);
    chk("input leds", o_input_indicator, 8'h5C);
    chk("output leds", o_output_indicator, 4'h6);
    chk("run dark", o_processor_indicator_a, `SMS_LED_OFF);
    $display("run test done");
  endtask
  task t_diag_fail;
    power_cycle();
    i_diag_fail = 1'h1;
    i_diag_done = 1'h1;
    wait_err();
    chk("no run", o_program_run, 1'h0);
    flash(1, 0, 40, 0, 0);
    $display("diagnosis fail test done");
  endtask
  task t_hw_fault;
    reach_run();
    i_app_safety_out = 4'hF;
    i_app_signal_out = 4'h5;
    i_system_in = 8'h33;
    step(4);
    i_hw_fault = 1'h1;
    wait_err();
    i_app_signal_out = 4'hA;
    i_system_in = 8'hCC;
    i_hw_fault = 1'h0;
    step(6);
    chk("safety open", o_safety_output_n, 4'h0);
    chk("signal frozen", o_signalling_output_n, 4'h5);
    chk("inputs ignored", o_program_in, 8'h33);
    chk("program stopped", o_program_run, 1'h0);
    chk("still error", o_in_error, 1'h1);
    flash(1, 0, 40, 0, 0);
    $display("hardware fault test done");
  endtask
  // One full period plus the first red of the repeat; pause is 30
  task t_restorable;
    integer c;
    for (c = 1; c <= 3; c = c + 1)
    begin
      reach_run();
      i_overcurrent = (c == 1);
      i_safe_short = (c == 2);
      i_temp_fault = (c == 3);
      wait_err();
      flash(2, c, 10 * c + 36, 30, 30);
    end
    $display("restorable fault test done");
  endtask
  task t_app_code;
    reach_run();
    i_app_error_code = 4'h2;
    i_app_error = 1'h1;
    wait_err();
    flash(0, 2, 40, 20, 30);
    // Code zero: dark pause only, never a flash
    reach_run();
    i_app_error_code = 4'h0;
    i_app_error = 1'h1;
    wait_err();
    flash(0, 0, 40, 40, 40);
    $display("application code test done");
  endtask
  task final_report;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    t_run();
    t_diag_fail();
    t_hw_fault();
    t_restorable();
    t_app_code();
    final_report();
  end
  // Tests need some 700 cycles; 20000 means a hang
  initial
  begin
    #500000;
    bad_count = bad_count + 1;
    final_report();
  end
endmodule // test_sms_supervisor
